// ### swm_pkg.sv
// constants and types shared by the signed word math unit
package swm_pkg;
	// register offsets (word indices in the status file)
	localparam logic [3:0] ADDR_FLAGS = 4'h0;
	localparam logic [3:0] ADDR_OPT = 4'h2;
	localparam logic [3:0] ADDR_TRAP = 4'h5;
	localparam logic [3:0] ADDR_MATH_LO = 4'hD;
	localparam logic [3:0] ADDR_MATH_HI = 4'hE;
	// field positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_OVF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_SIGN = 3;
	localparam int OPT_TRUNC = 14;
	localparam int TRAP_MINOR = 0;
	// reset value, fault code and saturation limits
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] FAULT_CODE = 16'h0020;
	localparam logic [15:0] WORD_MAX = 16'h7FFF;
	localparam logic [15:0] WORD_MIN = 16'h8000;
	// timing counts
	localparam logic [4:0] DIV_STEPS = 5'h1F;
	localparam logic [31:0] ROOT_BIT_START = 32'h4000_0000;
	// operation codes
	typedef enum logic [3:0] {
		SWM_OP_ADD = 4'h0,
		SWM_OP_SUB = 4'h1,
		SWM_OP_PRODUCT = 4'h2,
		SWM_OP_DIV = 4'h3,
		SWM_OP_LONG_QUOTIENT = 4'h4,
		SWM_OP_ZERO_WORD = 4'h5,
		SWM_OP_ROOT = 4'h6,
		SWM_OP_SCALE = 4'h7,
		SWM_OP_MOVE = 4'h8,
		SWM_OP_LOGIC = 4'h9,
		SWM_OP_BCD_IN = 4'hA,
		SWM_OP_BCD_OUT = 4'hB,
		SWM_OP_END = 4'hC,
		SWM_OP_TEMPORARY_END = 4'hD
	} swm_op_t;
	typedef enum logic [1:0] {
		SWM_IDLE = 2'b00,
		SWM_DIVIDE = 2'b01,
		SWM_ROOT = 2'b10,
		SWM_FINISH = 2'b11
	} swm_state_t;
endpackage

// ### swm_math_unit.sv
// signed 16-bit math unit with status flags, trap bit and math register
// How it works
// - add writes a plus b
// - subtract writes a minus b
// - carry set on add carry out
// - truncate bit keeps low sixteen bits
// - zero flag from stored result
// - sign flag from stored result
// - flags in low four bits, all ops but bcd and end
// - move and logic update zero, sign
// - trap sticky on overflow or div zero
// - trap at end raises fault 0020
// - low math word: low part, remainder
// - high math word: high part, quotient
// - bcd digits split across math words
// - multiply writes product
// - divide stores destination and math register
// - long divide uses 32-bit math register
// - zero word op clears destination
// - root op stores integer root
// - scale multiplies rate, adds offset
// - carry set on subtract borrow
// - truncate bit ignored by long divide
// - divide rounds up at half remainder
// - full product kept in math register
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module swm_math_unit (
	input wire logic clk,
	input wire logic reset,
	// operation request
	input wire logic op_start,
	input wire logic [3:0] op_code,
	input wire logic [15:0] operand_a,
	input wire logic [15:0] operand_b,
	input wire logic [15:0] operand_c,
	// operation answer
	output logic op_done,
	output logic [15:0] dest_word,
	output logic busy,
	output logic major_fault,
	output logic [15:0] fault_code,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata
);
	swm_pkg::swm_state_t state;
	logic [15:0] flags;
	logic trunc_sel;
	logic trap;
	logic [15:0] math_lo;
	logic [15:0] math_hi;
	// iterative divider / root working set
	logic [31:0] work_num;
	logic [31:0] work_rem;
	logic [31:0] work_quo;
	logic [16:0] work_den;
	logic [4:0] step;
	logic div_long;
	logic num_neg;
	logic den_neg;
	logic [31:0] root_val;
	logic [31:0] root_bit;
	logic [31:0] root_num;
	// combinational results of single-cycle ops
	logic signed [16:0] sum17;
	logic signed [31:0] prod32;
	logic signed [31:0] scale32;
	logic [15:0] res_word;
	logic res_ovf;
	logic res_carry;
	logic [16:0] sum_u;
	logic [16:0] dif_u;
	logic [31:0] rem_abs;
	logic [31:0] quo_signed;
	logic [31:0] rem_signed;
	logic [31:0] quo_round;
	logic div_ovf;
	logic [15:0] div_word;
	logic [31:0] next_rem;
	logic [31:0] bcd_val;
	logic [19:0] bcd_digits;
	logic trap_hit;
	logic end_taken;
	function automatic logic [15:0] fit16(input logic signed [31:0] v, input logic tr,
		output logic ovf);
		ovf = (v > 32'sh0000_7FFF) || (v < -32'sh0000_8000);
		if (!ovf || tr)
			fit16 = v[15:0];
		else
			fit16 = v[31] ? swm_pkg::WORD_MIN : swm_pkg::WORD_MAX;
	endfunction
	always_comb begin
		// carry and borrow come from the unsigned view of the words
		sum_u = {1'b0, operand_a} + {1'b0, operand_b};
		dif_u = {1'b0, operand_a} - {1'b0, operand_b};
		sum17 = 17'(signed'(operand_a)) + 17'(signed'(operand_b));
		prod32 = 32'(signed'(operand_a)) * 32'(signed'(operand_b));
		scale32 = 32'(signed'(operand_a)) * 32'(signed'(operand_b))
			+ 32'(signed'(operand_c));
		res_word = swm_pkg::RESET_WORD;
		res_ovf = 1'b0;
		res_carry = 1'b0;
		unique case (swm_pkg::swm_op_t'(op_code))
			swm_pkg::SWM_OP_ADD: begin
				res_word = fit16(32'(sum17), trunc_sel, res_ovf);
				res_carry = sum_u[16];
			end
			swm_pkg::SWM_OP_SUB: begin
				res_word = fit16(32'(17'(signed'(operand_a)) - 17'(signed'(operand_b))),
					trunc_sel, res_ovf);
				res_carry = dif_u[16];
			end
			swm_pkg::SWM_OP_PRODUCT: res_word = fit16(prod32, trunc_sel, res_ovf);
			swm_pkg::SWM_OP_SCALE: res_word = fit16(scale32, trunc_sel, res_ovf);
			swm_pkg::SWM_OP_ZERO_WORD: res_word = swm_pkg::RESET_WORD;
			default: res_word = operand_a;
		endcase
	end
	// divider signed fix-up and rounding
	always_comb begin
		rem_abs = work_rem;
		quo_signed = (num_neg ^ den_neg) ? (~work_quo + 32'h0000_0001) : work_quo;
		rem_signed = num_neg ? (~rem_abs + 32'h0000_0001) : rem_abs;
		// round half up on the magnitude, before the sign is put back
		quo_round = work_quo
			+ {31'h0000_0000, ({rem_abs[30:0], 1'b0} >= {15'h0000, work_den})};
		if (num_neg ^ den_neg)
			quo_round = ~quo_round + 32'h0000_0001;
		div_word = fit16(div_long ? quo_signed : quo_round, div_long ? 1'b1 : trunc_sel,
			div_ovf);
		if (div_long && div_ovf)
			div_word = quo_signed[31] ? swm_pkg::WORD_MIN : swm_pkg::WORD_MAX;
		next_rem = {work_rem[30:0], work_num[31]};
		bcd_val = {16'h0000, operand_a};
		// shift and add three: five digits cover the whole unsigned word
		bcd_digits = 20'h00000;
		for (int i = 15; i >= 0; i--) begin
			for (int d = 0; d < 5; d++)
				if (bcd_digits[d*4 +: 4] >= 4'h5)
					bcd_digits[d*4 +: 4] = bcd_digits[d*4 +: 4] + 4'h3;
			bcd_digits = {bcd_digits[18:0], bcd_val[i]};
		end
	end
	// sequencing of single-cycle and iterative operations
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= swm_pkg::SWM_IDLE;
			op_done <= 1'b0;
			busy <= 1'b0;
			dest_word <= swm_pkg::RESET_WORD;
			flags <= swm_pkg::RESET_WORD;
			math_lo <= swm_pkg::RESET_WORD;
			math_hi <= swm_pkg::RESET_WORD;
			work_num <= 32'h0000_0000;
			work_rem <= 32'h0000_0000;
			work_quo <= 32'h0000_0000;
			work_den <= 17'h00000;
			step <= 5'h00;
			div_long <= 1'b0;
			num_neg <= 1'b0;
			den_neg <= 1'b0;
			root_val <= 32'h0000_0000;
			root_bit <= 32'h0000_0000;
			root_num <= 32'h0000_0000;
		end else begin
			op_done <= 1'b0;
			unique case (state)
				swm_pkg::SWM_IDLE: begin
					// flags and math words are software's only while no iterative op owns them
					if (reg_write && reg_addr == swm_pkg::ADDR_FLAGS)
						flags <= {12'h000, reg_wdata[3:0]};
					if (reg_write && reg_addr == swm_pkg::ADDR_MATH_LO)
						math_lo <= reg_wdata;
					if (reg_write && reg_addr == swm_pkg::ADDR_MATH_HI)
						math_hi <= reg_wdata;
					if (op_start) begin
						unique case (swm_pkg::swm_op_t'(op_code))
							swm_pkg::SWM_OP_DIV, swm_pkg::SWM_OP_LONG_QUOTIENT: begin
								// operands are copied into the working set, so the caller may move on
								div_long <= (op_code == 4'(swm_pkg::SWM_OP_LONG_QUOTIENT));
								if (op_code == 4'(swm_pkg::SWM_OP_LONG_QUOTIENT)) begin
									// the long divisor comes on operand_b, as for the plain divide
									num_neg <= math_hi[15];
									work_num <= math_hi[15] ? (~{math_hi, math_lo} + 32'h0000_0001)
										: {math_hi, math_lo};
									den_neg <= operand_b[15];
									work_den <= operand_b[15] ? (17'h00000 - {1'b1, operand_b})
										: {1'b0, operand_b};
								end else begin
									num_neg <= operand_a[15];
									work_num <= operand_a[15] ? (32'h0000_0000 - {{16{1'b1}}, operand_a})
										: {16'h0000, operand_a};
									den_neg <= operand_b[15];
									work_den <= operand_b[15] ? (17'h00000 - {1'b1, operand_b})
										: {1'b0, operand_b};
								end
								work_rem <= 32'h0000_0000;
								work_quo <= 32'h0000_0000;
								step <= swm_pkg::DIV_STEPS;
								busy <= 1'b1;
								state <= swm_pkg::SWM_DIVIDE;
							end
							swm_pkg::SWM_OP_ROOT: begin
								root_num <= operand_a[15] ? {16'h0000, 16'h0000 - operand_a}
									: {16'h0000, operand_a};
								root_val <= 32'h0000_0000;
								root_bit <= swm_pkg::ROOT_BIT_START;
								busy <= 1'b1;
								state <= swm_pkg::SWM_ROOT;
							end
							swm_pkg::SWM_OP_MOVE, swm_pkg::SWM_OP_LOGIC: begin
								// carry and overflow stay as the last math op left them
								dest_word <= operand_a;
								flags[swm_pkg::FLAG_ZERO] <= (operand_a == 16'h0000);
								flags[swm_pkg::FLAG_SIGN] <= operand_a[15];
								op_done <= 1'b1;
							end
							swm_pkg::SWM_OP_BCD_OUT: begin
								math_lo <= bcd_digits[15:0];
								math_hi <= {12'h000, bcd_digits[19:16]};
								dest_word <= bcd_digits[15:0];
								op_done <= 1'b1;
							end
							swm_pkg::SWM_OP_BCD_IN: begin
								// a value past the word is cut to sixteen bits; keep digits in range
								dest_word <= 16'((math_hi[3:0] * 17'h02710)
									+ (math_lo[15:12] * 17'h003E8)
									+ (math_lo[11:8] * 17'h00064)
									+ (math_lo[7:4] * 17'h0000A) + math_lo[3:0]);
								op_done <= 1'b1;
							end
							swm_pkg::SWM_OP_END, swm_pkg::SWM_OP_TEMPORARY_END: op_done <= 1'b1;
							default: begin
								dest_word <= res_word;
								flags[swm_pkg::FLAG_CARRY] <= res_carry;
								flags[swm_pkg::FLAG_OVF] <= res_ovf;
								flags[swm_pkg::FLAG_ZERO] <= (res_word == 16'h0000);
								flags[swm_pkg::FLAG_SIGN] <= res_word[15];
								if (op_code == 4'(swm_pkg::SWM_OP_PRODUCT)) begin
									math_lo <= prod32[15:0];
									math_hi <= prod32[31:16];
								end
								op_done <= 1'b1;
							end
						endcase
					end
				end
				swm_pkg::SWM_DIVIDE: begin
					// restoring division, one quotient bit per clock
					// a zero divisor stops after one step; the finish state fixes the answer
					if (next_rem >= {15'h0000, work_den}) begin
						work_rem <= next_rem - {15'h0000, work_den};
						work_quo <= {work_quo[30:0], 1'b1};
					end else begin
						work_rem <= next_rem;
						work_quo <= {work_quo[30:0], 1'b0};
					end
					work_num <= {work_num[30:0], 1'b0};
					step <= step - 5'h01;
					if (work_den == 17'h00000 || step == 5'h00)
						state <= swm_pkg::SWM_FINISH;
				end
				swm_pkg::SWM_ROOT: begin
					if (root_bit == 32'h0000_0000) begin
						// round to nearest: a leftover above the root means past one half
						dest_word <= root_val[15:0] + {15'h0000, (root_num > root_val)};
						flags[swm_pkg::FLAG_CARRY] <= 1'b0;
						flags[swm_pkg::FLAG_OVF] <= 1'b0;
						flags[swm_pkg::FLAG_ZERO] <= (root_val == 32'h0000_0000);
						flags[swm_pkg::FLAG_SIGN] <= 1'b0;
						busy <= 1'b0;
						op_done <= 1'b1;
						state <= swm_pkg::SWM_IDLE;
					end else begin
						if (root_num >= root_val + root_bit) begin
							root_num <= root_num - (root_val + root_bit);
							root_val <= (root_val >> 1) + root_bit;
						end else begin
							root_val <= root_val >> 1;
						end
						root_bit <= root_bit >> 2;
					end
				end
				swm_pkg::SWM_FINISH: begin
					if (work_den == 17'h00000) begin
						// a zero divisor leaves the math register as it was
						dest_word <= swm_pkg::WORD_MAX;
						flags[swm_pkg::FLAG_OVF] <= 1'b1;
						flags[swm_pkg::FLAG_ZERO] <= 1'b0;
						flags[swm_pkg::FLAG_SIGN] <= 1'b0;
					end else begin
						dest_word <= div_word;
						math_hi <= quo_signed[15:0];
						math_lo <= rem_signed[15:0];
						flags[swm_pkg::FLAG_OVF] <= div_ovf;
						flags[swm_pkg::FLAG_ZERO] <= (div_word == 16'h0000);
						flags[swm_pkg::FLAG_SIGN] <= div_word[15];
					end
					flags[swm_pkg::FLAG_CARRY] <= 1'b0;
					busy <= 1'b0;
					op_done <= 1'b1;
					state <= swm_pkg::SWM_IDLE;
				end
			endcase
		end
	end
	// the trap rises at the edge the offending result lands, so an end taken right
	// behind that op sees it; flags left by an earlier op never raise it again
	always_comb begin
		trap_hit = 1'b0;
		if (state == swm_pkg::SWM_IDLE && op_start)
			trap_hit = res_ovf;
		else if (state == swm_pkg::SWM_FINISH)
			trap_hit = (work_den == 17'h00000) || div_ovf;
		end_taken = op_start && state == swm_pkg::SWM_IDLE
			&& (op_code == 4'(swm_pkg::SWM_OP_END)
			|| op_code == 4'(swm_pkg::SWM_OP_TEMPORARY_END));
	end
	// sticky trap: hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (reset)
			trap <= 1'b0;
		else if (trap_hit)
			trap <= 1'b1;
		else if (reg_write && reg_addr == swm_pkg::ADDR_TRAP)
			trap <= reg_wdata[swm_pkg::TRAP_MINOR];
	end
	// truncation only steers destination words, never the math register
	always_ff @(posedge clk) begin
		if (reset)
			trunc_sel <= 1'b0;
		else if (reg_write && reg_addr == swm_pkg::ADDR_OPT)
			trunc_sel <= reg_wdata[swm_pkg::OPT_TRUNC];
	end
	// fault is latched until reset; the trap bit alone does not clear it
	always_ff @(posedge clk) begin
		if (reset) begin
			major_fault <= 1'b0;
			fault_code <= swm_pkg::RESET_WORD;
		end else if (end_taken && trap) begin
			major_fault <= 1'b1;
			fault_code <= swm_pkg::FAULT_CODE;
		end
	end
	// read data stand for one cycle after the strobe and are zero otherwise
	always_ff @(posedge clk) begin
		if (reset)
			reg_rdata <= swm_pkg::RESET_WORD;
		else if (reg_read) begin
			unique case (reg_addr)
				swm_pkg::ADDR_FLAGS: reg_rdata <= {12'h000, flags[3:0]};
				swm_pkg::ADDR_OPT: reg_rdata <= {1'b0, trunc_sel, 14'h0000};
				swm_pkg::ADDR_TRAP: reg_rdata <= {15'h0000, trap};
				swm_pkg::ADDR_MATH_LO: reg_rdata <= math_lo;
				swm_pkg::ADDR_MATH_HI: reg_rdata <= math_hi;
				default: reg_rdata <= swm_pkg::RESET_WORD;
			endcase
		end else
			reg_rdata <= swm_pkg::RESET_WORD;
	end
endmodule

// ### swm_math_unit_assertions.sv
// port-level assertions for the signed word math unit
`timescale 1ns/1ps
module swm_math_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// operation side
	input wire logic op_start,
	input wire logic [3:0] op_code,
	input wire logic [15:0] operand_a,
	input wire logic [15:0] operand_b,
	input wire logic [15:0] operand_c,
	input wire logic op_done,
	input wire logic [15:0] dest_word,
	input wire logic busy,
	input wire logic major_fault,
	input wire logic [15:0] fault_code,
	// register side
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [16:0] sum;
	logic [16:0] diff;
	logic signed [31:0] prod;
	// one extra sign bit shows when the true result leaves the word
	assign sum = {operand_a[15], operand_a} + {operand_b[15], operand_b};
	assign diff = {operand_a[15], operand_a} - {operand_b[15], operand_b};
	assign prod = $signed(operand_a) * $signed(operand_b);
	sequence take(logic [3:0] code);
		op_start && !busy && op_code == code;
	endsequence
	a_add_sum: assert property (take(swm_pkg::SWM_OP_ADD) ##0 sum[16] == sum[15]
		|=> dest_word == $past(sum[15:0])) else $error("add result wrong");
	a_sub_diff: assert property (take(swm_pkg::SWM_OP_SUB) ##0 diff[16] == diff[15]
		|=> dest_word == $past(diff[15:0])) else $error("subtract result wrong");
	a_product_fit: assert property (take(swm_pkg::SWM_OP_PRODUCT)
		##0 (prod[31:15] == 17'h00000 || prod[31:15] == 17'h1FFFF)
		|=> dest_word == $past(prod[15:0])) else $error("product result wrong");
	a_clear_dest: assert property (take(swm_pkg::SWM_OP_ZERO_WORD)
		|=> op_done && dest_word == 16'h0000) else $error("clear left bits set");
	a_single_done: assert property (op_start && !busy && op_code inside {4'h0, 4'h1, 4'h2,
		4'h5, 4'h7, 4'h8} |=> op_done) else $error("single-cycle op not done");
	a_div_done: assert property (take(swm_pkg::SWM_OP_DIV)
		|=> busy ##[1:60] op_done) else $error("divide did not finish");
	a_root_done: assert property (take(swm_pkg::SWM_OP_ROOT)
		|=> busy ##[1:30] op_done) else $error("root did not finish");
	a_fault_latch: assert property (major_fault |=> major_fault)
		else $error("major fault dropped");
	a_fault_code: assert property (major_fault |-> fault_code == swm_pkg::FAULT_CODE)
		else $error("fault code wrong");
endmodule
bind swm_math_unit swm_math_assertions chk (.clk(clk), .reset(reset), .op_start(op_start),
	.op_code(op_code), .operand_a(operand_a), .operand_b(operand_b), .operand_c(operand_c),
	.op_done(op_done), .dest_word(dest_word), .busy(busy), .major_fault(major_fault),
	.fault_code(fault_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

// ### swm_math_unit_tb.sv
// self-checking bench for the signed word math unit
`timescale 1ns/1ps
module swm_math_unit_tb;
	logic clk, reset, op_start, op_done, busy, major_fault, reg_write, reg_read;
	logic [3:0] op_code, reg_addr;
	logic [15:0] operand_a, operand_b, operand_c, dest_word, fault_code, reg_wdata, reg_rdata;
	logic [3:0] addrs [6] = '{4'h0, 4'h2, 4'h5, 4'hD, 4'hE, 4'h7};
	int errors, n_compared;
	swm_math_unit uut (.clk(clk), .reset(reset), .op_start(op_start), .op_code(op_code),
		.operand_a(operand_a), .operand_b(operand_b), .operand_c(operand_c),
		.op_done(op_done), .dest_word(dest_word), .busy(busy), .major_fault(major_fault),
		.fault_code(fault_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test;
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task reg_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		check($sformatf("reg %h", a), reg_rdata, e);
	endtask
	// issue one op, wait for its done pulse, then compare busy and the destination
	task do_op(input logic [3:0] code, input logic [15:0] a, b, c, e);
		@(posedge clk);
		op_code <= code;
		operand_a <= a;
		operand_b <= b;
		operand_c <= c;
		op_start <= 1'b1;
		@(posedge clk);
		op_start <= 1'b0;
		#1;
		repeat (100) if (op_done !== 1'b1) @(posedge clk) #1;
		check("done", {15'h0000, op_done}, 16'h0001);
		check("busy", {15'h0000, busy}, 16'h0000);
		check("dest", dest_word, e);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		stop_test;
	end
	initial begin
		errors = 0;
		n_compared = 0;
		reset = 1'b1;
		{op_start, reg_write, reg_read} = 3'h0;
		op_code = 4'h0;
		{operand_a, operand_b, operand_c, reg_wdata} = 64'h0;
		reg_addr = 4'h0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		foreach (addrs[i]) reg_chk(addrs[i], 16'h0000);
		do_op(4'h0, 16'h0001, 16'h0002, 16'h0000, 16'h0003);
		reg_chk(4'h0, 16'h0000);
		do_op(4'h0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000);
		reg_chk(4'h0, 16'h0005);
		do_op(4'h0, 16'h7FFF, 16'h0001, 16'h0000, 16'h7FFF);
		reg_chk(4'h0, 16'h0002);
		reg_chk(4'h5, 16'h0001);
		reg_wr(4'h2, 16'h4000);
		do_op(4'h0, 16'h7FFF, 16'h0001, 16'h0000, 16'h8000);
		reg_chk(4'h0, 16'h000A);
		do_op(4'h2, 16'h012C, 16'h00C8, 16'h0000, 16'hEA60);
		reg_chk(4'hD, 16'hEA60);
		reg_chk(4'hE, 16'h0000);
		reg_wr(4'h2, 16'h0000);
		do_op(4'h2, 16'h012C, 16'h00C8, 16'h0000, 16'h7FFF);
		do_op(4'h2, 16'hFFFD, 16'h0004, 16'h0000, 16'hFFF4);
		reg_wr(4'h5, 16'h0000);
		reg_chk(4'h5, 16'h0000);
		do_op(4'h1, 16'h0003, 16'h0005, 16'h0000, 16'hFFFE);
		reg_chk(4'h0, 16'h0009);
		do_op(4'h3, 16'h0007, 16'h0002, 16'h0000, 16'h0004);
		reg_chk(4'hD, 16'h0001);
		reg_chk(4'hE, 16'h0003);
		reg_wr(4'hE, 16'h0001);
		reg_wr(4'hD, 16'h0000);
		do_op(4'h4, 16'h0000, 16'h0004, 16'h0000, 16'h4000);
		reg_chk(4'hE, 16'h4000);
		reg_chk(4'hD, 16'h0000);
		do_op(4'h5, 16'h1234, 16'h0000, 16'h0000, 16'h0000);
		reg_chk(4'h0, 16'h0004);
		do_op(4'h6, 16'h0010, 16'h0000, 16'h0000, 16'h0004);
		do_op(4'h7, 16'h000A, 16'h0003, 16'h0005, 16'h0023);
		do_op(4'h8, 16'h8000, 16'h0000, 16'h0000, 16'h8000);
		reg_chk(4'h0, 16'h0008);
		do_op(4'hB, 16'h3039, 16'h0000, 16'h0000, 16'h2345);
		reg_chk(4'hD, 16'h2345);
		reg_chk(4'hE, 16'h0001);
		do_op(4'hA, 16'h0000, 16'h0000, 16'h0000, 16'h3039);
		do_op(4'h9, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		reg_chk(4'h0, 16'h0004);
		do_op(4'h3, 16'h0005, 16'h0000, 16'h0000, 16'h7FFF);
		reg_chk(4'h5, 16'h0001);
		reg_wr(4'h5, 16'h0000);
		do_op(4'hD, 16'h0000, 16'h0000, 16'h0000, 16'h7FFF);
		check("fault", {15'h0000, major_fault}, 16'h0000);
		do_op(4'h0, 16'h7FFF, 16'h0001, 16'h0000, 16'h7FFF);
		do_op(4'hC, 16'h0000, 16'h0000, 16'h0000, 16'h7FFF);
		check("fault", {15'h0000, major_fault}, 16'h0001);
		check("code", fault_code, 16'h0020);
		stop_test;
	end
endmodule
